// file: ftsr_defines.svh
// Purpose: constants for the frame trigger and sequence controller
// Assumes: 25 MHz clock
// Notes:   offsets and counts as macros
`ifndef FTSR_DEFINES_SVH
`define FTSR_DEFINES_SVH
`define FTSR_SRC_W        4
`define FTSR_SEQ_ENTRIES  10
`define FTSR_IDX_W        4
`define FTSR_IDX_OFF      4'hf
`define FTSR_CNT_W        8
`define FTSR_DIM_W        16
`define FTSR_GAIN_W       12
`define FTSR_EXP_W        24
`define FTSR_DLY_W        24
`define FTSR_READOUT_CYC  16'h0040
`endif

// file: ftsr_pkg.sv
// Purpose: types for the frame trigger and sequence controller
// Assumes: nothing
// Notes:   source and mode encodings
package ftsr_pkg;
  typedef enum logic [3:0] {
    FTSR_SRC_LINE0, FTSR_SRC_LINE1, FTSR_SRC_LINE2, FTSR_SRC_LINE3,
    FTSR_SRC_TMR_START, FTSR_SRC_TMR_END,
    FTSR_SRC_CNT_START, FTSR_SRC_CNT_END,
    FTSR_SRC_UOUT0, FTSR_SRC_UOUT1, FTSR_SRC_UOUT2, FTSR_SRC_UOUT3,
    FTSR_SRC_ACT1, FTSR_SRC_ACT2, FTSR_SRC_SOFT
  } ftsr_src_t;
  typedef enum logic [1:0] {
    FTSR_MODE_NORMAL, FTSR_MODE_SEQ, FTSR_MODE_MULTI
  } ftsr_mode_t;
endpackage : ftsr_pkg

// file: ftsr_trig_sel.sv
// Purpose: trigger source selection and edge detection
// Assumes: synchronous inputs
// Notes:   software command yields a pulse directly
`timescale 1ns/1ps
`default_nettype none
`include "ftsr_defines.svh"
module ftsr_trig_sel (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire ftsr_pkg::ftsr_src_t src_i,
  input  wire logic             falling_i,
  input  wire logic [3:0]       line_i,
  input  wire logic             tmr_start_i,
  input  wire logic             tmr_end_i,
  input  wire logic             cnt_start_i,
  input  wire logic             cnt_end_i,
  input  wire logic [3:0]       uout_i,
  input  wire logic [1:0]       action_i,
  input  wire logic             sw_trig_i,
  output logic                  trig_o
);
  import ftsr_pkg::*;
  logic lvl;
  logic lvl_r;
  logic [15:0] all;
  assign all = {1'b0, sw_trig_i, action_i, uout_i, cnt_end_i, cnt_start_i,
                tmr_end_i, tmr_start_i, line_i};
  // source mux [RULE1] [RULE6]
  assign lvl = all[src_i];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_r <= 1'b0;
    end else if (ce_i) begin
      lvl_r <= lvl;
    end
  end
  // edge choice [RULE2]; software fires per command [RULE4]
  always_comb begin
    if (src_i == FTSR_SRC_SOFT) begin
      trig_o = ce_i & sw_trig_i;
    end else if (falling_i) begin
      trig_o = ce_i & lvl_r & ~lvl;
    end else begin
      trig_o = ce_i & ~lvl_r & lvl;
    end
  end
endmodule : ftsr_trig_sel
`default_nettype wire

// file: ftsr_ctrl.sv
// Purpose: frame start trigger, delay, exposure and sequence ROI control
// Assumes: one clock, inputs synchronous, host writes table via ports
// Notes:   readout length is a parameter
// Contract
// [RULE1] frame trigger taken from one selected source
// [RULE2] rising or falling edge per activation setting
// [RULE3] configurable delay from edge to frame start, zero normal
// [RULE4] software source triggers once per software command
// [RULE5] host selects software source before issuing the command
// [RULE6] user output bit selected as source triggers by its value
// [RULE7] modes normal, sequence, multi; sequencing only in sequence mode
// [RULE8] table of ten entries with count, next, window, gain, exposure
// [RULE9] after an entry, continue at its next index
// [RULE10] next index OFF ends the sequence
// [RULE11] each entry captures its frame count of frames
// [RULE12] overlap off ignores triggers in readout; overlap on accepts them
// [RULE13] timed exposure uses configured or entry exposure time
`timescale 1ns/1ps
`default_nettype none
`include "ftsr_defines.svh"
module ftsr_ctrl #(
  parameter int READOUT_CYC = `FTSR_READOUT_CYC
) (
  // clock and reset
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_I,
  input  wire logic                     CE_I,
  // trigger config and sources
  input  wire ftsr_pkg::ftsr_src_t      TRIG_SRC_I,
  input  wire logic                     TRIG_FALLING_I,
  input  wire logic [`FTSR_DLY_W-1:0]   TRIG_DELAY_I,
  input  wire logic                     TRIG_OVL_READOUT_I,
  input  wire logic [3:0]               LINE_I,
  input  wire logic                     TMR_START_I,
  input  wire logic                     TMR_END_I,
  input  wire logic                     CNT_START_I,
  input  wire logic                     CNT_END_I,
  input  wire logic [3:0]               USER_OUT_I,
  input  wire logic [1:0]               ACTION_I,
  input  wire logic                     SW_TRIG_I,
  // exposure and mode
  input  wire logic                     EXP_TIMED_I,
  input  wire logic [`FTSR_EXP_W-1:0]   EXP_TIME_I,
  input  wire ftsr_pkg::ftsr_mode_t     MODE_I,
  // sequence table write
  input  wire logic                     SEQ_WE_I,
  input  wire logic [`FTSR_IDX_W-1:0]   SEQ_WIDX_I,
  input  wire logic [`FTSR_CNT_W-1:0]   SEQ_WCNT_I,
  input  wire logic [`FTSR_IDX_W-1:0]   SEQ_WNEXT_I,
  input  wire logic [`FTSR_DIM_W-1:0]   SEQ_WWIDTH_I,
  input  wire logic [`FTSR_DIM_W-1:0]   SEQ_WHEIGHT_I,
  input  wire logic [`FTSR_DIM_W-1:0]   SEQ_WOFFX_I,
  input  wire logic [`FTSR_DIM_W-1:0]   SEQ_WOFFY_I,
  input  wire logic [`FTSR_GAIN_W-1:0]  SEQ_WGAIN_I,
  input  wire logic [`FTSR_EXP_W-1:0]   SEQ_WEXP_I,
  input  wire logic                     SEQ_START_I,
  // frame outputs
  output logic                          FRAME_START_O,
  output logic                          EXPOSING_O,
  output logic                          READOUT_O,
  output logic                          SEQ_ACTIVE_O,
  output logic [`FTSR_IDX_W-1:0]        SEQ_IDX_O,
  output logic [`FTSR_DIM_W-1:0]        ROI_WIDTH_O,
  output logic [`FTSR_DIM_W-1:0]        ROI_HEIGHT_O,
  output logic [`FTSR_DIM_W-1:0]        ROI_OFFX_O,
  output logic [`FTSR_DIM_W-1:0]        ROI_OFFY_O,
  output logic [`FTSR_GAIN_W-1:0]       ROI_GAIN_O,
  output logic [`FTSR_EXP_W-1:0]        EXP_USED_O
);
  import ftsr_pkg::*;
  localparam int N = `FTSR_SEQ_ENTRIES;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_EXPOSE} ftsr_st_t;

  logic [`FTSR_CNT_W-1:0]  cnt_m   [N];
  logic [`FTSR_IDX_W-1:0]  next_m  [N];
  logic [`FTSR_DIM_W-1:0]  w_m     [N];
  logic [`FTSR_DIM_W-1:0]  h_m     [N];
  logic [`FTSR_DIM_W-1:0]  x_m     [N];
  logic [`FTSR_DIM_W-1:0]  y_m     [N];
  logic [`FTSR_GAIN_W-1:0] g_m     [N];
  logic [`FTSR_EXP_W-1:0]  e_m     [N];
  ftsr_st_t                st_r;
  logic [`FTSR_DLY_W-1:0]  dly_r;
  logic [`FTSR_EXP_W-1:0]  exp_r;
  logic [15:0]             ro_r;
  logic [`FTSR_CNT_W-1:0]  done_r;
  logic                    trig;
  logic                    accept;
  logic                    seq_on;
  logic                    exp_end;
  logic [`FTSR_EXP_W-1:0]  exp_pick;

  ftsr_trig_sel u_sel (
    .clk_i       (MCLK_I),
    .rst_i       (RST_I),
    .ce_i        (CE_I),
    .src_i       (TRIG_SRC_I),
    .falling_i   (TRIG_FALLING_I),
    .line_i      (LINE_I),
    .tmr_start_i (TMR_START_I),
    .tmr_end_i   (TMR_END_I),
    .cnt_start_i (CNT_START_I),
    .cnt_end_i   (CNT_END_I),
    .uout_i      (USER_OUT_I),
    .action_i    (ACTION_I),
    .sw_trig_i   (SW_TRIG_I),
    .trig_o      (trig)
  );

  // sequencing only in sequence mode [RULE7]
  assign seq_on = SEQ_ACTIVE_O && (MODE_I == FTSR_MODE_SEQ);
  // readout gating [RULE12]
  assign accept = trig && st_r == ST_IDLE && (ro_r == 16'h0000
                  || TRIG_OVL_READOUT_I);
  assign exp_end = st_r == ST_EXPOSE && exp_r <= 24'h000001;
  // exposure for the coming frame [RULE13]
  assign exp_pick = !EXP_TIMED_I ? 24'h000001
                  : seq_on ? e_m[SEQ_IDX_O] : EXP_TIME_I;

  // table storage [RULE8]
  always_ff @(posedge MCLK_I) begin
    if (CE_I && SEQ_WE_I && SEQ_WIDX_I < 4'(N)) begin
      cnt_m[SEQ_WIDX_I]  <= SEQ_WCNT_I;
      next_m[SEQ_WIDX_I] <= SEQ_WNEXT_I;
      w_m[SEQ_WIDX_I]    <= SEQ_WWIDTH_I;
      h_m[SEQ_WIDX_I]    <= SEQ_WHEIGHT_I;
      x_m[SEQ_WIDX_I]    <= SEQ_WOFFX_I;
      y_m[SEQ_WIDX_I]    <= SEQ_WOFFY_I;
      g_m[SEQ_WIDX_I]    <= SEQ_WGAIN_I;
      e_m[SEQ_WIDX_I]    <= SEQ_WEXP_I;
    end
  end

  // frame state machine: delay then expose [RULE3] [RULE13]
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st_r          <= ST_IDLE;
      dly_r         <= '0;
      exp_r         <= '0;
      FRAME_START_O <= 1'b0;
    end else if (CE_I) begin
      FRAME_START_O <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          if (accept) begin
            dly_r <= TRIG_DELAY_I;
            st_r  <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (dly_r == '0) begin
            FRAME_START_O <= 1'b1;
            exp_r <= exp_pick;
            st_r  <= ST_EXPOSE;
          end else begin
            dly_r <= dly_r - 1'b1;
          end
        end
        ST_EXPOSE: begin
          if (exp_end) begin
            st_r <= ST_IDLE;
          end else begin
            exp_r <= exp_r - 1'b1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // readout counter
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ro_r <= '0;
    end else if (CE_I) begin
      if (exp_end) begin
        ro_r <= 16'(READOUT_CYC);
      end else if (ro_r != '0) begin
        ro_r <= ro_r - 1'b1;
      end
    end
  end

  // sequence walk [RULE9] [RULE10] [RULE11]
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      SEQ_ACTIVE_O <= 1'b0;
      SEQ_IDX_O    <= '0;
      done_r       <= '0;
    end else if (CE_I) begin
      if (SEQ_START_I && MODE_I == FTSR_MODE_SEQ) begin
        SEQ_ACTIVE_O <= 1'b1;
        SEQ_IDX_O    <= '0;
        done_r       <= '0;
      end else if (seq_on && exp_end) begin
        if (done_r + 1'b1 >= cnt_m[SEQ_IDX_O]) begin
          done_r <= '0;
          if (next_m[SEQ_IDX_O] == `FTSR_IDX_OFF
              || next_m[SEQ_IDX_O] >= 4'(N)) begin
            SEQ_ACTIVE_O <= 1'b0;
          end else begin
            SEQ_IDX_O <= next_m[SEQ_IDX_O];
          end
        end else begin
          done_r <= done_r + 1'b1;
        end
      end
    end
  end

  // region outputs registered at frame start in sequence mode; exposure used at every frame start
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ROI_WIDTH_O  <= '0;
      ROI_HEIGHT_O <= '0;
      ROI_OFFX_O   <= '0;
      ROI_OFFY_O   <= '0;
      ROI_GAIN_O   <= '0;
      EXP_USED_O   <= '0;
    end else if (CE_I && st_r == ST_DELAY && dly_r == '0 && seq_on) begin
      ROI_WIDTH_O  <= w_m[SEQ_IDX_O];
      ROI_HEIGHT_O <= h_m[SEQ_IDX_O];
      ROI_OFFX_O   <= x_m[SEQ_IDX_O];
      ROI_OFFY_O   <= y_m[SEQ_IDX_O];
      ROI_GAIN_O   <= g_m[SEQ_IDX_O];
      EXP_USED_O   <= exp_pick;
    end else if (CE_I && st_r == ST_DELAY && dly_r == '0) begin
      EXP_USED_O   <= exp_pick;
    end
  end

  assign EXPOSING_O = st_r == ST_EXPOSE;
  assign READOUT_O  = ro_r != '0;

  // checks
  property p_delay;
    @(posedge MCLK_I) disable iff (RST_I)
    (CE_I && st_r == ST_IDLE && accept && TRIG_DELAY_I == '0) ##1 CE_I
      |=> FRAME_START_O;
  endproperty
  a_delay: assert property (p_delay) else $error("delay zero late"); // [RULE3]
  property p_ovl;
    @(posedge MCLK_I) disable iff (RST_I)
    (st_r == ST_IDLE && READOUT_O && !TRIG_OVL_READOUT_I && CE_I)
      |=> st_r == ST_IDLE;
  endproperty
  a_ovl: assert property (p_ovl) else $error("trigger in readout"); // [RULE12]
  property p_mode;
    @(posedge MCLK_I) disable iff (RST_I)
    (MODE_I != FTSR_MODE_SEQ && CE_I) |=> $stable(SEQ_IDX_O);
  endproperty
  a_mode: assert property (p_mode) else $error("seq outside mode"); // [RULE7]
  property p_soft;
    @(posedge MCLK_I) disable iff (RST_I)
    (CE_I && TRIG_SRC_I == FTSR_SRC_SOFT && SW_TRIG_I && st_r == ST_IDLE
      && !READOUT_O) |=> st_r == ST_DELAY;
  endproperty
  a_soft: assert property (p_soft) else $error("soft lost"); // [RULE4]
  property p_exp;
    @(posedge MCLK_I) disable iff (RST_I)
    (CE_I && st_r == ST_DELAY && dly_r == '0 && EXP_TIMED_I
      && !SEQ_ACTIVE_O) |=> exp_r == $past(EXP_TIME_I);
  endproperty
  a_exp: assert property (p_exp) else $error("exposure time"); // [RULE13]
  property p_end;
    @(posedge MCLK_I) disable iff (RST_I)
    (CE_I && seq_on && exp_end && !SEQ_START_I && done_r == '0
      && cnt_m[SEQ_IDX_O] == 8'h01 && next_m[SEQ_IDX_O] == `FTSR_IDX_OFF)
      |=> !SEQ_ACTIVE_O;
  endproperty
  a_end: assert property (p_end) else $error("seq not ended"); // [RULE10]
  c_frame: cover property (@(posedge MCLK_I) FRAME_START_O);
  c_seq_end: cover property (@(posedge MCLK_I) $fell(SEQ_ACTIVE_O));
  c_ovl: cover property (@(posedge MCLK_I) accept && READOUT_O);
endmodule : ftsr_ctrl
`default_nettype wire

// file: ftsr_src_mdl.sv
// Purpose: trigger source and host command model
// Assumes: driven from bench tasks at the falling edge
// Notes:   bit s of lvl is the level of source code s
`timescale 1ns/1ps
`default_nettype none
module ftsr_src_mdl (
  // clock
  input  wire logic  clk_i,
  // source levels
  output logic [3:0] line_o,
  output logic       tmr_s_o,
  output logic       tmr_e_o,
  output logic       cnt_s_o,
  output logic       cnt_e_o,
  output logic [3:0] uout_o,
  output logic [1:0] act_o,
  // software command
  output logic       sw_o
);
  logic [13:0] lvl = 14'h0000;
  initial sw_o = 1'b0;
  assign line_o = lvl[3:0];
  assign {cnt_e_o, cnt_s_o, tmr_e_o, tmr_s_o} = lvl[7:4];
  assign uout_o = lvl[11:8]; // selected user bit is the source
  assign act_o = lvl[13:12];
  task automatic set_lvl(input int s, input logic v);
    lvl[s] = v;
  endtask : set_lvl
  task automatic soft_cmd();
    sw_o = 1'b1;
    @(negedge clk_i);
    sw_o = 1'b0;
  endtask : soft_cmd
endmodule : ftsr_src_mdl
`default_nettype wire

// file: ftsr_ctrl_tb_top.sv
// Purpose: self-checking bench for the frame trigger controller
// Assumes: readout shortened to 4 cycles
// Notes:   driver queues frame notes, monitor checks them
`timescale 1ns/1ps
`default_nettype none
module ftsr_ctrl_tb_top;
  import ftsr_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, ovl = 1'b0, fall = 1'b0;
  logic        we = 1'b0, start = 1'b0, timed = 1'b1;
  ftsr_src_t   src = FTSR_SRC_SOFT;
  ftsr_mode_t  mode = FTSR_MODE_NORMAL;
  logic [23:0] dly = '0, expt = 24'h000004, wexp = 24'h000001;
  logic [3:0]  widx = '0, wnext = '0, line, uout, sidx;
  logic [7:0]  wcnt = '0;
  logic [15:0] ww = '0, rw, rh, rx, ry, lf = 16'd27470;
  logic [1:0]  act;
  logic        ts, te, cs, ce, sw, fs, expo, ro, sact;
  logic [11:0] rg;
  logic [23:0] eu;
  logic [15:0] tw[10];
  logic [23:0] tx[10];
  logic [40:0] notes[$];
  int          bad_count = 0, checked = 0;

  ftsr_src_mdl u_src (.clk_i(clk), .line_o(line), .tmr_s_o(ts),
    .tmr_e_o(te), .cnt_s_o(cs), .cnt_e_o(ce), .uout_o(uout),
    .act_o(act), .sw_o(sw));
  ftsr_ctrl #(.READOUT_CYC(4)) dut (.MCLK_I(clk), .RST_I(rst),
    .CE_I(1'b1), .TRIG_SRC_I(src), .TRIG_FALLING_I(fall),
    .TRIG_DELAY_I(dly), .TRIG_OVL_READOUT_I(ovl), .LINE_I(line),
    .TMR_START_I(ts), .TMR_END_I(te), .CNT_START_I(cs), .CNT_END_I(ce),
    .USER_OUT_I(uout), .ACTION_I(act), .SW_TRIG_I(sw),
    .EXP_TIMED_I(timed), .EXP_TIME_I(expt), .MODE_I(mode),
    .SEQ_WE_I(we), .SEQ_WIDX_I(widx), .SEQ_WCNT_I(wcnt),
    .SEQ_WNEXT_I(wnext), .SEQ_WWIDTH_I(ww), .SEQ_WHEIGHT_I(~ww),
    .SEQ_WOFFX_I(ww), .SEQ_WOFFY_I(ww), .SEQ_WGAIN_I(ww[11:0]),
    .SEQ_WEXP_I(wexp), .SEQ_START_I(start), .FRAME_START_O(fs),
    .EXPOSING_O(expo), .READOUT_O(ro), .SEQ_ACTIVE_O(sact),
    .SEQ_IDX_O(sidx), .ROI_WIDTH_O(rw), .ROI_HEIGHT_O(rh),
    .ROI_OFFX_O(rx), .ROI_OFFY_O(ry), .ROI_GAIN_O(rg), .EXP_USED_O(eu));

  initial begin
    forever #20 clk = ~clk;
  end
  task automatic conclude();
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [23:0] a, input logic [23:0] e);
    checked++;
    if (a !== e) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    expt = {19'h0, lf[4:0]} + 24'h000001;
  endtask : rnd
  task automatic note(input logic c, input logic [15:0] w,
                      input logic [23:0] e);
    notes.push_back({c, w, e});
  endtask : note
  task automatic idle();
    int n;
    n = 0;
    repeat (int'(dly) + 4) @(negedge clk);
    while ((expo || ro || fs) && n < 300) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
  endtask : idle
  task automatic wr(input logic [3:0] i, input logic [7:0] c,
                    input logic [3:0] nx);
    rnd();
    {widx, wcnt, wnext, ww, wexp, we} = {i, c, nx, lf, expt, 1'b1};
    {tw[i], tx[i]} = {lf, expt};
    @(negedge clk);
  endtask : wr

  always @(negedge clk) begin : mon
    logic [40:0] n;
    int k;
    if (fs === 1'b1) begin
      k = 0;
      n = (notes.size() > 0) ? notes.pop_front() : '1;
      if (&n) chk(24'h000001, 24'h000000);
      while (expo === 1'b1 && k < 300) begin
        k++;
        @(negedge clk);
      end
      chk(24'(k), n[23:0]);
      chk(eu, n[23:0]);
      if (n[40]) chk({8'h00, rw}, {8'h00, n[39:24]});
      if (n[40]) chk({8'h00, rh}, {8'h00, ~n[39:24]});
      if (n[40]) chk({8'h00, rx}, {8'h00, n[39:24]});
      if (n[40]) chk({8'h00, ry}, {8'h00, n[39:24]});
      if (n[40]) chk({12'h000, rg}, {12'h000, n[35:24]});
    end
  end

  initial begin : main
    int s, n;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    // every source but software; rising sources even, falling odd
    for (s = 0; s < 14; s++) begin
      src = ftsr_src_t'(s);
      fall = s[0];
      rnd();
      u_src.set_lvl(s, 1'b1);
      if (!fall) note(1'b0, 16'h0000, expt);
      idle();
      u_src.set_lvl(s, 1'b0);
      if (fall) note(1'b0, 16'h0000, expt);
      idle();
    end
    // software source selected before the command
    src = FTSR_SRC_SOFT;
    for (s = 0; s < 2; s++) begin
      dly = 24'(s * 5);
      note(1'b0, 16'h0000, expt);
      u_src.soft_cmd();
      n = 1;
      while (fs !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      chk(24'(n), dly + 24'h000002);
      idle();
    end
    dly = '0;
    // untimed exposure lasts one cycle
    timed = 1'b0;
    note(1'b0, 16'h0000, 24'h000001);
    u_src.soft_cmd();
    idle();
    timed = 1'b1;
    // trigger during readout, overlap off then on
    for (s = 0; s < 2; s++) begin
      ovl = s[0];
      note(1'b0, 16'h0000, expt);
      u_src.soft_cmd();
      n = 0;
      while (ro !== 1'b1 && n < 300) begin
        @(negedge clk);
        n++;
      end
      if (ovl) note(1'b0, 16'h0000, expt);
      u_src.soft_cmd();
      n = 0;
      while (ro === 1'b1 && n < 300) begin
        @(negedge clk);
        n++;
      end
      if (!ovl) chk(24'(n), 24'h000003);
      idle();
    end
    // sequence: 0 twice, then 9, then 1 which ends it
    mode = FTSR_MODE_SEQ;
    wr(4'h0, 8'h02, 4'h9);
    wr(4'h9, 8'h01, 4'h1);
    wr(4'h1, 8'h01, 4'hf);
    we = 1'b0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    chk({23'h0, sact}, 24'h000001);
    foreach (tw[i]) begin
      if (i < 4) begin
        n = (i < 2) ? 0 : (i == 2) ? 9 : 1;
        note(1'b1, tw[n], tx[n]);
        chk({20'h00000, sidx}, 24'(n));
        u_src.soft_cmd();
        idle();
      end
    end
    chk({23'h0, sact}, 24'h000000);
    mode = FTSR_MODE_MULTI;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (2) @(negedge clk);
    chk({23'h0, sact}, 24'h000000);
    chk(24'(notes.size()), 24'h000000);
    conclude();
  end

  initial begin : watchdog
    #(40 * 40000);
    bad_count++;
    conclude();
  end
endmodule : ftsr_ctrl_tb_top
`default_nettype wire
